// ===== core/lsio_bank.sv
// Logic signal I/O bank: 32 logic outputs, 32 logic inputs, event records.
//
// Function
// - Thirty-two output bits, each driven from the user logic program.
// - Each output bit is routable to blocking, group, relay and LED sinks; here the bits only leave on logic_out_bit, with no routing.
// - Current output bit states are readable over the supervisory link.
// - A setting selects ON, OFF or both kinds to store; others dropped.
// - Every recorded input or output event carries a time stamp.
// - Thirty-two input bits, each settable by a control command.
// - Set and clear commands accepted from mimic switch and supervisory link.
// - Input bits are not retained; all read 0 after restart.
// - Hold mode: set drives 1, stays until clear or restart.
// - Pulse mode: set drives 1, bit self-clears after 5 ms.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lsio_bank #(
  parameter int NCH         = 32,
  parameter int PULSE_TICKS = lsio_pkg::PULSE_TICKS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [31:0] user_logic_out,
  input  wire logic [31:0] mimic_set,
  input  wire logic [31:0] mimic_clr,
  output logic [31:0]      logic_out_bit,
  output logic [31:0]      logic_in_bit,
  input  wire logic        evt_ready,
  output logic             evt_valid,
  output logic [5:0]       evt_chan,
  output logic             evt_on,
  output logic [31:0]      evt_stamp,
  output logic             irq
);
  localparam int TCW = $clog2(lsio_pkg::TICK_CYCLES);
  localparam int PCW = $clog2(PULSE_TICKS + 1);

  // ==========================================================
  // Bus slave state
  logic        wr_pend_reg, wr_pend_next;
  logic        rd_pend_reg, rd_pend_next;
  logic [7:0]  addr_reg, addr_next;
  logic        rdy_reg, rdy_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        resp_reg;
  logic        accept;
  logic        wr_now;
  logic        rd_now;
  logic [31:0] rd_mux;

  // ==========================================================
  // Block state
  logic [31:0]       out_reg, out_next;
  logic [31:0]       in_reg, in_next;
  logic [31:0]       mode_reg, mode_next;
  logic [1:0]        sel_reg, sel_next;
  logic [TCW-1:0]    tdiv_reg, tdiv_next;
  logic              tick_reg, tick_next;
  logic [31:0]       ts_reg, ts_next;
  logic [lsio_pkg::IRQ_W-1:0] stat_reg;
  logic [lsio_pkg::IRQ_W-1:0] stat_next;
  logic [lsio_pkg::IRQ_W-1:0] mask_reg;
  logic [lsio_pkg::IRQ_W-1:0] mask_next;
  logic              irq_reg, irq_next;
  logic [31:0]       set_cmd;
  logic [31:0]       clr_cmd;
  logic [31:0]       expire;
  logic [31:0]       o_rise;
  logic [31:0]       o_fall;
  logic [31:0]       i_rise;
  logic [31:0]       i_fall;
  logic              ev_lost;
  logic [PCW-1:0]    cnt_reg [NCH];
  logic [PCW-1:0]    cnt_next [NCH];

  // ==========================================================
  // Register map, one word per offset, decoded from haddr[7:2]:
  //   OUT_STATE  output bit states, read only.
  //   IN_STATE   input bit states, read only.
  //   IN_SET     a one in a bit sets that input; reads as zero.
  //   IN_CLR     a one in a bit clears that input; reads as zero.
  //   IN_MODE    a one selects the self-clearing pulse mode.
  //   EVT_SEL    bit 0 keeps ON records, bit 1 keeps OFF records.
  //   IRQ_STAT   sticky status, cleared by a read.
  //   IRQ_MASK   enables status bits onto the interrupt.
  //   TSTAMP     microseconds since reset; wraps after about 71 minutes.
  // Unmapped offsets read as zero and ignore writes.

  // ==========================================================
  // Bus front end: writes finish with no wait, reads insert one wait
  // state so they always see the result of an immediately preceding write.
  // Only single whole-word transfers are expected: hsize is not decoded,
  // so a narrow write still replaces the whole register.
  always_comb begin
    accept       = hsel && htrans[1] && hready;
    wr_now       = wr_pend_reg;
    rd_now       = rd_pend_reg;
    wr_pend_next = accept && hwrite;
    rd_pend_next = accept && !hwrite;
    addr_next    = accept ? {haddr[7:2], 2'b00} : addr_reg;
    rdy_next     = !(accept && !hwrite);
    rdata_next   = rd_now ? rd_mux : rdata_reg;
  end

  always_comb begin
    unique case (addr_reg)
      lsio_pkg::OUT_STATE_OFS: rd_mux = out_reg;
      lsio_pkg::IN_STATE_OFS:  rd_mux = in_reg;
      lsio_pkg::IN_MODE_OFS:   rd_mux = mode_reg;
      lsio_pkg::EVT_SEL_OFS:   rd_mux = {30'h0, sel_reg};
      lsio_pkg::IRQ_STAT_OFS:  rd_mux = {28'h0, stat_reg};
      lsio_pkg::IRQ_MASK_OFS:  rd_mux = {28'h0, mask_reg};
      lsio_pkg::TSTAMP_OFS:    rd_mux = ts_reg;
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      rdy_reg     <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
      resp_reg    <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg    <= addr_next;
      rdy_reg     <= rdy_next;
      rdata_reg   <= rdata_next;
      resp_reg    <= 1'b0;
    end
  end

  // ==========================================================
  // Commands from the mimic and the link; set wins over clear.
  // A mimic set and a set over the bus in one cycle both take effect.
  always_comb begin
    set_cmd = mimic_set;
    clr_cmd = mimic_clr;
    if (wr_now && addr_reg == lsio_pkg::IN_SET_OFS) begin
      set_cmd = set_cmd | hwdata;
    end
    if (wr_now && addr_reg == lsio_pkg::IN_CLR_OFS) begin
      clr_cmd = clr_cmd | hwdata;
    end
  end

  // ==========================================================
  // Fixed timebase tick and time stamp counter.
  // One tick per TICK_CYCLES clocks gives the microsecond time base.
  // The divider runs free from reset, so a pulse's first tick comes early.
  always_comb begin
    tick_next = (tdiv_reg == TCW'(lsio_pkg::TICK_CYCLES - 1));
    tdiv_next = tick_next ? '0 : tdiv_reg + 1'b1;
    ts_next   = tick_reg ? ts_reg + 32'h0000_0001 : ts_reg;
  end

  // ==========================================================
  // Per-channel input bit with hold or self-clearing pulse behaviour.
  // A bit switched from hold to pulse while high clears a pulse time later;
  // one switched back to hold while high stays high until cleared.
  // Counting one tick past the pulse length keeps the bit high for at
  // least the full pulse time and at most one tick longer.
  for (genvar i = 0; i < NCH; i++) begin : g_in
    always_comb begin
      in_next[i]  = in_reg[i];
      cnt_next[i] = cnt_reg[i];
      expire[i]   = 1'b0;
      if (set_cmd[i]) begin
        in_next[i]  = 1'b1;
        cnt_next[i] = PCW'(PULSE_TICKS);
      end else if (clr_cmd[i]) begin
        in_next[i] = 1'b0;
      end else if (mode_reg[i] && in_reg[i] && tick_reg) begin
        if (cnt_reg[i] == '0) begin
          in_next[i] = 1'b0;
          expire[i]  = 1'b1;
        end else begin
          cnt_next[i] = cnt_reg[i] - 1'b1;
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        in_reg[i]  <= 1'b0;
        cnt_reg[i] <= '0;
      end else begin
        in_reg[i]  <= in_next[i];
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  // ==========================================================
  // Configuration, output capture, status and interrupt.
  // Output bits need no synchroniser: the user logic runs on this clock.
  // The interrupt is formed from the next status, so it rises with it.
  always_comb begin
    out_next  = user_logic_out;
    mode_next = mode_reg;
    sel_next  = sel_reg;
    mask_next = mask_reg;
    if (wr_now && addr_reg == lsio_pkg::IN_MODE_OFS) begin
      mode_next = hwdata;
    end
    if (wr_now && addr_reg == lsio_pkg::EVT_SEL_OFS) begin
      sel_next = hwdata[1:0];
    end
    if (wr_now && addr_reg == lsio_pkg::IRQ_MASK_OFS) begin
      mask_next = hwdata[lsio_pkg::IRQ_W-1:0];
    end
    // Edges are filtered by the selected kinds before they are queued.
    o_rise = out_next & ~out_reg
             & {32{sel_reg[lsio_pkg::EVT_SEL_ON_BIT]}};
    o_fall = ~out_next & out_reg
             & {32{sel_reg[lsio_pkg::EVT_SEL_OFF_BIT]}};
    i_rise = in_next & ~in_reg
             & {32{sel_reg[lsio_pkg::EVT_SEL_ON_BIT]}};
    i_fall = ~in_next & in_reg
             & {32{sel_reg[lsio_pkg::EVT_SEL_OFF_BIT]}};
    stat_next = stat_reg;
    if (rd_now && addr_reg == lsio_pkg::IRQ_STAT_OFS) begin
      stat_next = '0;
    end
    stat_next[lsio_pkg::IRQ_OUT_CHG] = stat_next[lsio_pkg::IRQ_OUT_CHG]
                                       | (out_next != out_reg);
    stat_next[lsio_pkg::IRQ_IN_CHG]  = stat_next[lsio_pkg::IRQ_IN_CHG]
                                       | (in_next != in_reg);
    stat_next[lsio_pkg::IRQ_PULSE]   = stat_next[lsio_pkg::IRQ_PULSE]
                                       | (|expire);
    stat_next[lsio_pkg::IRQ_LOST]    = stat_next[lsio_pkg::IRQ_LOST]
                                       | ev_lost;
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg  <= 32'h0000_0000;
      mode_reg <= lsio_pkg::IN_MODE_RST;
      sel_reg  <= lsio_pkg::EVT_SEL_RST;
      mask_reg <= lsio_pkg::IRQ_MASK_RST[lsio_pkg::IRQ_W-1:0];
      stat_reg <= '0;
      irq_reg  <= 1'b0;
      tdiv_reg <= '0;
      tick_reg <= 1'b0;
      ts_reg   <= 32'h0000_0000;
    end else begin
      out_reg  <= out_next;
      mode_reg <= mode_next;
      sel_reg  <= sel_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      irq_reg  <= irq_next;
      tdiv_reg <= tdiv_next;
      tick_reg <= tick_next;
      ts_reg   <= ts_next;
    end
  end

  // ==========================================================
  // Event records: channels 0..31 form the output block, 32..63 the input
  // block, so channel bit 5 names the block.
  // A slow sink never stalls the bits: a second edge on a pending channel
  // replaces its record and raises the lost status bit.
  lsio_evq #(
    .N  (64),
    .CW (6),
    .TW (32)
  ) u_evq (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .rise      ({i_rise, o_rise}),
    .fall      ({i_fall, o_fall}),
    .stamp     (ts_reg),
    .evt_ready (evt_ready),
    .evt_valid (evt_valid),
    .evt_chan  (evt_chan),
    .evt_on    (evt_on),
    .evt_stamp (evt_stamp),
    .lost      (ev_lost)
  );

  assign hreadyout     = rdy_reg;
  assign hresp         = resp_reg;
  assign hrdata        = rdata_reg;
  assign logic_out_bit = out_reg;
  assign logic_in_bit  = in_reg;
  assign irq           = irq_reg;
endmodule : lsio_bank
`default_nettype wire

// ===== core/lsio_pkg.sv
// Shared constants of the logic signal I/O bank.
package lsio_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OUT_STATE_OFS = 8'h00;
  localparam logic [7:0] IN_STATE_OFS  = 8'h04;
  localparam logic [7:0] IN_SET_OFS    = 8'h08;
  localparam logic [7:0] IN_CLR_OFS    = 8'h0c;
  localparam logic [7:0] IN_MODE_OFS   = 8'h10;
  localparam logic [7:0] EVT_SEL_OFS   = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h1c;
  localparam logic [7:0] TSTAMP_OFS    = 8'h20;
  // ==========================================================
  // Field positions and reset values
  localparam int EVT_SEL_ON_BIT  = 0;
  localparam int EVT_SEL_OFF_BIT = 1;
  localparam logic [1:0] EVT_SEL_RST = 2'h3;
  localparam logic [31:0] IN_MODE_RST  = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
  localparam int IRQ_OUT_CHG = 0;
  localparam int IRQ_IN_CHG  = 1;
  localparam int IRQ_PULSE   = 2;
  localparam int IRQ_LOST    = 3;
  localparam int IRQ_W       = 4;
  // ==========================================================
  // Timing
  localparam int SYS_CLK_HZ  = 40_000_000;
  localparam int TICK_NS     = 1000;
  localparam int TICK_CYCLES = (SYS_CLK_HZ / 1000 * TICK_NS + 999_999)
                               / 1_000_000;
  localparam int PULSE_MS    = 5;
  localparam int PULSE_TICKS = PULSE_MS * 1_000_000 / TICK_NS;
endpackage : lsio_pkg

// ===== core/lsio_evq.sv
// Pending-event scanner that emits one time-stamped change record at a time.
`timescale 1ns/1ps
`default_nettype none
module lsio_evq #(
  parameter int N  = 64,
  parameter int CW = 6,
  parameter int TW = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic [N-1:0]  rise,
  input  wire logic [N-1:0]  fall,
  input  wire logic [TW-1:0] stamp,
  input  wire logic          evt_ready,
  output logic               evt_valid,
  output logic [CW-1:0]      evt_chan,
  output logic               evt_on,
  output logic [TW-1:0]      evt_stamp,
  output logic               lost
);
  logic [N-1:0]  pend_reg, pend_next;
  logic [N-1:0]  dir_reg, dir_next;
  logic [TW-1:0] stamp_mem [N];
  logic          valid_reg, valid_next;
  logic [CW-1:0] chan_reg, chan_next;
  logic          on_reg, on_next;
  logic [TW-1:0] st_reg, st_next;
  logic          lost_reg, lost_next;
  logic          found;
  logic [CW-1:0] pick;
  logic          load;
  logic [N-1:0]  hit;

  // ==========================================================
  // Lowest pending channel wins, so output events beat input events.
  always_comb begin
    found = 1'b0;
    pick  = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        found = 1'b1;
        pick  = CW'(i);
      end
    end
  end

  always_comb begin
    hit        = rise | fall;
    load       = found && (!valid_reg || evt_ready);
    pend_next  = pend_reg;
    if (load) begin
      pend_next[pick] = 1'b0;
    end
    // A new edge is kept even when its channel is drained this cycle.
    pend_next  = pend_next | hit;
    dir_next   = (dir_reg & ~hit) | rise;
    lost_next  = |(hit & pend_reg & ~(load ? (N'(1) << pick) : '0));
    valid_next = load || (valid_reg && !evt_ready);
    chan_next  = load ? pick : chan_reg;
    on_next    = load ? dir_reg[pick] : on_reg;
    st_next    = load ? stamp_mem[pick] : st_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg  <= '0;
      dir_reg   <= '0;
      valid_reg <= 1'b0;
      chan_reg  <= '0;
      on_reg    <= 1'b0;
      st_reg    <= '0;
      lost_reg  <= 1'b0;
    end else begin
      pend_reg  <= pend_next;
      dir_reg   <= dir_next;
      valid_reg <= valid_next;
      chan_reg  <= chan_next;
      on_reg    <= on_next;
      st_reg    <= st_next;
      lost_reg  <= lost_next;
    end
  end

  // Each record keeps the time of its edge, not the time it leaves.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < N; i++) begin
      if (hit[i]) begin
        stamp_mem[i] <= stamp;
      end
    end
  end

  assign evt_valid = valid_reg;
  assign evt_chan  = chan_reg;
  assign evt_on    = on_reg;
  assign evt_stamp = st_reg;
  assign lost      = lost_reg;
endmodule : lsio_evq
`default_nettype wire

// ===== bench/lsio_bank_sva.sv
// Port-level assertions for the logic signal I/O bank.
`timescale 1ns/1ps
`default_nettype none
module lsio_bank_sva (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] user_logic_out,
  input wire logic [31:0] mimic_set,
  input wire logic [31:0] mimic_clr,
  input wire logic [31:0] logic_out_bit,
  input wire logic [31:0] logic_in_bit,
  input wire logic        evt_ready,
  input wire logic        evt_valid,
  input wire logic [5:0]  evt_chan,
  input wire logic        evt_on,
  input wire logic [31:0] evt_stamp
);
  // ==========
  // Checks
  logic [31:0] clr_q;
  always_ff @(posedge sys_clk) begin
    clr_q <= mimic_clr & ~mimic_set;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence rd_take_s;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence wr_take_s;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  sequence stall_s;
    evt_valid && !evt_ready;
  endsequence
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  read_wait_a: assert property (rd_take_s |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_fast_a: assert property (wr_take_s |=> hreadyout)
    else $error("write stalled");
  out_follow_a: assert property ($past(rst_n) |->
    logic_out_bit == $past(user_logic_out)) else $error("output lag");
  set_wins_a: assert property (mimic_set != 32'h0 |=>
    (logic_in_bit & $past(mimic_set)) == $past(mimic_set))
    else $error("set lost");
  clear_cmd_a: assert property ((mimic_clr & ~mimic_set) != 32'h0 |=>
    (logic_in_bit & clr_q) == 32'h0) else $error("clear lost");
  boot_zero_a: assert property ($rose(rst_n) |-> logic_in_bit == 32'h0)
    else $error("input kept over restart");
  evt_hold_a: assert property (stall_s |=> evt_valid &&
    $stable(evt_chan) && $stable(evt_on) && $stable(evt_stamp))
    else $error("record changed while stalled");
endmodule : lsio_bank_sva
bind lsio_bank lsio_bank_sva u_lsio_bank_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .user_logic_out(user_logic_out), .mimic_set(mimic_set),
  .mimic_clr(mimic_clr), .logic_out_bit(logic_out_bit),
  .logic_in_bit(logic_in_bit), .evt_ready(evt_ready),
  .evt_valid(evt_valid), .evt_chan(evt_chan), .evt_on(evt_on),
  .evt_stamp(evt_stamp));
`default_nettype wire

// ===== bench/lsio_sink.sv
// Event sink and user logic model on the far side of the I/O bank.
`timescale 1ns/1ps
`default_nettype none
module lsio_sink #(
  parameter int DLY = 400
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic [31:0] pat,
  input  wire logic [31:0] in_bit,
  input  wire logic        evt_valid,
  input  wire logic [5:0]  evt_chan,
  input  wire logic        evt_on,
  input  wire logic [31:0] evt_stamp,
  output logic             evt_ready,
  output logic [31:0]      user_out
);
  // ==========
  // Model
  logic [9:0] dly_cnt;
  logic       ph;
  logic [6:0] rec[$];
  logic [31:0] stp[$];
  // A slow sink takes one record every other cycle, so records must stand.
  assign evt_ready = !slow || ph;
  // Falling-edge delay stretches input bit 0 onto output bit 31.
  assign user_out = {dly_cnt != 10'h0, pat[30:0]};
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_cnt <= 10'h0;
      ph      <= 1'b0;
    end else begin
      ph <= !ph;
      if (in_bit[0]) begin
        dly_cnt <= 10'(DLY);
      end else if (dly_cnt != 10'h0) begin
        dly_cnt <= dly_cnt - 10'h1;
      end
      if (evt_valid && evt_ready) begin
        rec.push_back({evt_on, evt_chan});
        stp.push_back(evt_stamp);
      end
    end
  end
endmodule : lsio_sink
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the logic signal I/O bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========
  // Bench
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic        slow    = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] pat     = 32'h0;
  logic [31:0] mset    = 32'h0;
  logic [31:0] mclr    = 32'h0;
  logic        rdy, resp, ev_rdy, ev_v, ev_on, irq;
  logic [5:0]  ev_ch;
  logic [31:0] rdata, ulo, lob, lib, ev_ts, q, t;
  int          err_total = 0;
  int          total_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  lsio_bank #(.PULSE_TICKS(5)) u_lsio_bank (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(rdy), .hreadyout(rdy), .hresp(resp), .hrdata(rdata),
    .user_logic_out(ulo), .mimic_set(mset), .mimic_clr(mclr),
    .logic_out_bit(lob), .logic_in_bit(lib), .evt_ready(ev_rdy),
    .evt_valid(ev_v), .evt_chan(ev_ch), .evt_on(ev_on),
    .evt_stamp(ev_ts), .irq(irq));
  lsio_sink u_lsio_sink (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
    .pat(pat), .in_bit(lib), .evt_valid(ev_v), .evt_chan(ev_ch),
    .evt_on(ev_on), .evt_stamp(ev_ts), .evt_ready(ev_rdy), .user_out(ulo));
  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(negedge sys_clk); while (rdy !== 1'b1);
    @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge sys_clk); while (rdy !== 1'b1);
    q = rdata;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
    bus(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic pls(input logic [31:0] s, c);
    @(posedge sys_clk);
    mset <= s;
    mclr <= c;
    @(posedge sys_clk);
    mset <= 32'h0;
    mclr <= 32'h0;
  endtask : pls
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    results();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(lsio_pkg::IN_STATE_OFS, 32'h0, "in_rst");
    rd(lsio_pkg::IN_MODE_OFS, lsio_pkg::IN_MODE_RST, "mode_rst");
    rd(lsio_pkg::EVT_SEL_OFS, 32'h3, "sel_rst");
    rd(8'h3c, 32'h0, "unmapped");
    @(posedge sys_clk) pat <= 32'h5a5a_0f0f;
    cyc(3);
    chk("out_port", lob, 32'h5a5a_0f0f);
    bus(1'b1, lsio_pkg::OUT_STATE_OFS, 32'h0);
    rd(lsio_pkg::OUT_STATE_OFS, 32'h5a5a_0f0f, "out_reg");
    @(posedge sys_clk) pat <= 32'h0;
    // Held inputs set from both sources survive time, then two of the three clear.
    bus(1'b1, lsio_pkg::IN_SET_OFS, 32'h8000_0008);
    pls(32'h10, 32'h0);
    cyc(300);
    rd(lsio_pkg::IN_STATE_OFS, 32'h8000_0018, "hold");
    bus(1'b1, lsio_pkg::IN_CLR_OFS, 32'h8000_0000);
    pls(32'h0, 32'h8);
    rd(lsio_pkg::IN_STATE_OFS, 32'h10, "clear");
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(lsio_pkg::IN_STATE_OFS, 32'h0, "reboot");
    bus(1'b1, lsio_pkg::IN_MODE_OFS, 32'h1);
    pls(32'h1, 32'h0);
    cyc(150);
    chk("pulse_hi", {31'h0, lib[0]}, 32'h1);
    cyc(120);
    chk("pulse_lo", {31'h0, lib[0]}, 32'h0);
    chk("stretch", {31'h0, lob[31]}, 32'h1);
    rd(lsio_pkg::IRQ_STAT_OFS, 32'h7, "pulse_stat");
    bus(1'b1, lsio_pkg::IN_MODE_OFS, 32'h0);
    cyc(450);
    bus(1'b1, lsio_pkg::IRQ_MASK_OFS, 32'h2);
    bus(1'b0, lsio_pkg::IRQ_STAT_OFS, 32'h0);
    pls(32'h10, 32'h0);
    cyc(4);
    chk("irq_on", {31'h0, irq}, 32'h1);
    rd(lsio_pkg::IRQ_STAT_OFS, 32'h2, "stat_rc");
    cyc(3);
    chk("irq_off", {31'h0, irq}, 32'h0);
    bus(1'b1, lsio_pkg::IRQ_MASK_OFS, 32'h0);
    pls(32'h0, 32'h10);
    cyc(4);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    bus(1'b0, lsio_pkg::TSTAMP_OFS, 32'h0);
    t = q;
    cyc(397);
    rd(lsio_pkg::TSTAMP_OFS, t + 32'd10, "tstamp");
    slow <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      bus(1'b1, lsio_pkg::EVT_SEL_OFS, 32'(s));
      u_lsio_sink.rec.delete();
      @(posedge sys_clk) pat <= 32'h80;
      cyc(20);
      @(posedge sys_clk) pat <= 32'h0;
      cyc(20);
      chk("evt_num", u_lsio_sink.rec.size(), 32'(s % 2 + s / 2));
      chk("evt_kind", {25'h0, u_lsio_sink.rec[0]}, {25'h0, s != 2, 6'd7});
    end
    bus(1'b0, lsio_pkg::TSTAMP_OFS, 32'h0);
    t = q;
    u_lsio_sink.rec.delete();
    u_lsio_sink.stp.delete();
    @(posedge sys_clk) pat <= 32'h24;
    cyc(20);
    pls(32'h4, 32'h0);
    cyc(20);
    chk("ord0", {25'h0, u_lsio_sink.rec[0]}, 32'h42);
    chk("ord1", {25'h0, u_lsio_sink.rec[1]}, 32'h45);
    chk("in_evt", {25'h0, u_lsio_sink.rec[2]}, 32'h62);
    chk("stamp_a", {31'h0, u_lsio_sink.stp[0] - t < 32'h2}, 32'h1);
    chk("stamp_b", {31'h0, u_lsio_sink.stp[1] - t < 32'h2}, 32'h1);
    chk("stamp_c", {31'h0, u_lsio_sink.stp[2] - t < 32'h2}, 32'h1);
    // A burst of rises undone next cycle overruns the slow sink.
    bus(1'b0, lsio_pkg::IRQ_STAT_OFS, 32'h0);
    @(posedge sys_clk) pat <= 32'hff;
    @(posedge sys_clk) pat <= 32'h0;
    cyc(40);
    rd(lsio_pkg::IRQ_STAT_OFS, 32'h9, "lost");
    results();
  end
endmodule : tb_top
`default_nettype wire
